// >>> hw/dpl_pkg.sv
// package: register map, field layouts, defaults and timing for the drive protection logic
package dpl_pkg;
  localparam int unsigned MCLK_HZ = 50000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = MCLK_HZ / 1000 * TICK_MS;
  localparam logic [11:0] MS_PER_SEC = 12'h3E8;

  localparam logic [11:0] ADDR_OVERLOAD = 12'h000;
  localparam logic [11:0] ADDR_STALL    = 12'h004;
  localparam logic [11:0] ADDR_PHASE    = 12'h008;
  localparam logic [11:0] ADDR_OUTSEL   = 12'h00C;
  localparam logic [11:0] ADDR_INPUTS   = 12'h010;
  localparam logic [11:0] ADDR_STATUS   = 12'h014;
  localparam logic [11:0] ADDR_CONTROL  = 12'h018;

  localparam logic [7:0] WARN_LEVEL_MIN = 8'h1E;
  localparam logic [7:0] WARN_LEVEL_MAX = 8'h96;
  localparam logic [7:0] WARN_LEVEL_DEF = 8'h96;
  localparam logic [5:0] WARN_TIME_MAX  = 6'h1E;
  localparam logic [5:0] WARN_TIME_DEF  = 6'h0A;
  localparam logic [7:0] TRIP_LEVEL_MIN = 8'h1E;
  localparam logic [7:0] TRIP_LEVEL_MAX = 8'hC8;
  localparam logic [7:0] TRIP_LEVEL_DEF = 8'hB4;
  localparam logic [5:0] TRIP_TIME_MAX  = 6'h3C;
  localparam logic [5:0] TRIP_TIME_DEF  = 6'h3C;
  localparam logic       TRIP_EN_DEF    = 1'b1;
  localparam logic [7:0] STALL_LEVEL_MIN = 8'h1E;
  localparam logic [7:0] STALL_LEVEL_MAX = 8'h96;
  localparam logic [7:0] STALL_LEVEL_DEF = 8'h96;
  localparam logic [2:0] STALL_MASK_DEF  = 3'h0;
  localparam logic [15:0] RATED_DEF      = 16'h0064;
  localparam logic [1:0] PHASE_SEL_DEF   = 2'h0;
  localparam logic [4:0] OUT_FUNC_DEF    = 5'h0C;
  localparam logic [4:0] RELAY_FUNC_DEF  = 5'h11;
  localparam logic [4:0] OUT_FUNC_MAX    = 5'h12;
  localparam logic [4:0] IN_FUNC_MAX     = 5'h19;

  localparam logic [4:0] FUNC_OVERLOAD = 5'h05;
  localparam logic [4:0] FUNC_STALL    = 5'h07;
  localparam logic [4:0] FUNC_FAULT    = 5'h11;
  localparam logic [4:0] FUNC_EXT_NO   = 5'h12;
  localparam logic [4:0] FUNC_EXT_NC   = 5'h13;

  localparam int unsigned NUM_INPUTS = 8;

  // field positions in the overload register
  localparam int unsigned OV_WLVL_LSB = 0;
  localparam int unsigned OV_WTIM_LSB = 8;
  localparam int unsigned OV_TLVL_LSB = 16;
  localparam int unsigned OV_TTIM_LSB = 24;
  localparam int unsigned OV_TEN_BIT  = 31;

  typedef enum logic [2:0] {
    DPL_RUN_STOP  = 3'b001,
    DPL_RUN_RAMP  = 3'b010,
    DPL_RUN_CONST = 3'b100
  } dpl_phase_t;

  typedef struct packed {
    logic overload_trip;
    logic out_phase;
    logic in_phase;
    logic capacitor;
    logic ext_trip;
  } dpl_fault_t;
endpackage

// >>> hw/dpl_top.sv
// drive protection logic: overload, stall, phase loss and external trip with apb registers
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (R01) overload warning level in percent of rated current, 30 to 150, default 150
// (R02) output or relay selector code 5 drives overload warning status
// (R03) warning asserts after current stays above level for warning time, 0 to 30 s
// (R04) overload trip enable bit lets motor overload cut the output
// (R05) output off after current above trip level for trip time; 30-200 %, 0-60 s
// (R06) stall mask bit 0: decelerate during acceleration when current exceeds stall level
// (R07) stall mask bit 1: decelerate during constant speed when current exceeds stall level
// (R08) stall mask bit 2: pause deceleration while dc link voltage above threshold
// (R09) stall level is a percentage of the rated current setting
// (R10) stall mask is three bits: acceleration, constant speed, deceleration
// (R11) stall code 7 on an output reports stall status even with mask zero
// (R12) phase loss select 0 none, 1 output, 2 input, 3 both
// (R13) output phase loss selected: any lost output phase shuts output off
// (R14) input phase loss selected: any lost supply phase blocks output
// (R15) input phase loss selected: capacitor end of life also shuts output off
// (R16) output phase loss detection depends on the rated current setting
// (R17) eight input function codes; 18 normally-open trip, 19 normally-closed trip
// (R18) closed normally-open trip contact flags a fault and turns output off
// (R19) opened normally-closed trip contact flags a fault and turns output off
// (R20) stall action may stretch a ramp beyond its configured time
// (R21) any trip forces output off until cleared by fault reset
module dpl_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // measurements from the power stage
  input  wire logic [15:0] motor_current,
  input  wire logic        dc_link_high,
  input  wire logic [2:0]  output_phase_ok,
  input  wire logic [2:0]  input_phase_ok,
  input  wire logic        capacitor_worn,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic        running,
  // external contacts
  input  wire logic [7:0]  input_contact,
  // drive commands and alarms
  output logic             output_enable,
  output logic             stall_decelerate,
  output logic             stall_hold_decel,
  output logic             ramp_stretch,
  output logic             open_collector_output,
  output logic             alarm_relay,
  output logic             fault_active
);
  // settings
  logic [7:0]  overload_warn_level;
  logic [5:0]  overload_warn_time;
  logic [7:0]  overload_trip_level;
  logic [5:0]  overload_trip_time;
  logic        overload_trip_enable;
  logic [2:0]  stall_phase_mask;
  logic [7:0]  stall_current_level;
  logic [15:0] motor_rated_current;
  logic [1:0]  phase_loss_select;
  logic [4:0]  output_terminal_function;
  logic [4:0]  relay_function;
  logic [4:0]  input_function [dpl_pkg::NUM_INPUTS];
  // state
  dpl_pkg::dpl_fault_t fault;
  dpl_pkg::dpl_phase_t run_phase;
  logic [15:0] tick_cnt;
  logic [9:0]  ms_cnt;
  logic [5:0]  warn_sec;
  logic [5:0]  trip_sec;
  logic        overload_warn;
  logic        stall_active;

  // apb decode
  wire        apb_wr    = psel & penable & pwrite;
  wire        hit_ovl   = paddr == dpl_pkg::ADDR_OVERLOAD;
  wire        hit_stall = paddr == dpl_pkg::ADDR_STALL;
  wire        hit_phase = paddr == dpl_pkg::ADDR_PHASE;
  wire        hit_osel  = paddr == dpl_pkg::ADDR_OUTSEL;
  wire        hit_in    = paddr == dpl_pkg::ADDR_INPUTS;
  wire        hit_stat  = paddr == dpl_pkg::ADDR_STATUS;
  wire        hit_ctl   = paddr == dpl_pkg::ADDR_CONTROL;
  wire        hit_any   = hit_ovl | hit_stall | hit_phase | hit_osel | hit_in | hit_stat | hit_ctl;
  wire        fault_clear = apb_wr & hit_ctl & pwdata[0];

  // out-of-range level and time writes are clamped, and out-of-range selector codes are stored as 0, so a setting never leaves its printed range
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [5:0] clamp6(input logic [5:0] v, input logic [5:0] hi);
    clamp6 = (v > hi) ? hi : v;
  endfunction

  // percent of rated current, 16x8 product kept wide to avoid overflow
  wire [23:0] cur_pct100  = {8'h00, motor_current} * 24'h000064;
  wire [23:0] warn_thr    = {8'h00, motor_rated_current} * {16'h0000, overload_warn_level}; // (R01)
  wire [23:0] trip_thr    = {8'h00, motor_rated_current} * {16'h0000, overload_trip_level};
  wire [23:0] stall_thr   = {8'h00, motor_rated_current} * {16'h0000, stall_current_level}; // (R09)
  wire        over_warn   = cur_pct100 > warn_thr;
  wire        over_trip   = cur_pct100 > trip_thr;
  wire        over_stall  = cur_pct100 > stall_thr;
  wire        sec_tick    = (tick_cnt == 16'(dpl_pkg::TICK_CYCLES - 1)) && (ms_cnt == 10'(dpl_pkg::MS_PER_SEC - 1));

  // stall phase qualifiers
  wire stall_accel = stall_phase_mask[0] & accelerating & over_stall; // (R06) (R10)
  wire stall_const = stall_phase_mask[1] & (run_phase == dpl_pkg::DPL_RUN_CONST) & over_stall; // (R07) (R10)
  wire stall_decel = stall_phase_mask[2] & decelerating & dc_link_high; // (R08) (R10)
  // status view is independent of the mask so code 7 works with the mask cleared
  wire stall_seen  = (over_stall & (accelerating | running)) | (decelerating & dc_link_high); // (R11)

  // output phase loss is only checked while running and with a nonzero rated current setting
  wire out_loss = (phase_loss_select[0]) & running & (motor_rated_current != 16'h0000)
                  & (output_phase_ok != 3'h7); // (R12) (R13) (R16)
  wire in_loss  = phase_loss_select[1] & (input_phase_ok != 3'h7); // (R12) (R14)
  wire cap_trip = phase_loss_select[1] & (input_phase_ok == 3'h7) & capacitor_worn; // (R15)
  wire ol_trip  = overload_trip_enable & over_trip &
                  (trip_sec >= overload_trip_time) & (overload_trip_time == 6'h00 || sec_tick | (trip_sec >= overload_trip_time)); // (R04) (R05)

  // external trip contacts, one lane per input
  wire [7:0] ext_hit;
  genvar gi;
  generate
    for (gi = 0; gi < dpl_pkg::NUM_INPUTS; gi++) begin : g_ext
      assign ext_hit[gi] = ((input_function[gi] == dpl_pkg::FUNC_EXT_NO) & input_contact[gi])   // (R17) (R18)
                         | ((input_function[gi] == dpl_pkg::FUNC_EXT_NC) & ~input_contact[gi]); // (R17) (R19)
    end
  endgenerate

  wire any_fault = |fault;

  function automatic logic sel_out(input logic [4:0] f, input logic ow, input logic st, input logic fl);
    case (f)
      dpl_pkg::FUNC_OVERLOAD: sel_out = ow; // (R02)
      dpl_pkg::FUNC_STALL:    sel_out = st; // (R11)
      dpl_pkg::FUNC_FAULT:    sel_out = fl;
      default:                sel_out = 1'b0;
    endcase
  endfunction

  dpl_pkg::dpl_phase_t next_run_phase;
  always_comb begin
    case (1'b1)
      (accelerating | decelerating): next_run_phase = dpl_pkg::DPL_RUN_RAMP;
      running:                       next_run_phase = dpl_pkg::DPL_RUN_CONST;
      default:                       next_run_phase = dpl_pkg::DPL_RUN_STOP;
    endcase
  end

  // register writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      overload_warn_level      <= dpl_pkg::WARN_LEVEL_DEF; // (R01)
      overload_warn_time       <= dpl_pkg::WARN_TIME_DEF; // (R03)
      overload_trip_level      <= dpl_pkg::TRIP_LEVEL_DEF; // (R05)
      overload_trip_time       <= dpl_pkg::TRIP_TIME_DEF; // (R05)
      overload_trip_enable     <= dpl_pkg::TRIP_EN_DEF;
      stall_phase_mask         <= dpl_pkg::STALL_MASK_DEF;
      stall_current_level      <= dpl_pkg::STALL_LEVEL_DEF;
      motor_rated_current      <= dpl_pkg::RATED_DEF;
      phase_loss_select        <= dpl_pkg::PHASE_SEL_DEF;
      output_terminal_function <= dpl_pkg::OUT_FUNC_DEF;
      relay_function           <= dpl_pkg::RELAY_FUNC_DEF;
    end else if (apb_wr) begin
      if (hit_ovl) begin
        overload_warn_level  <= clamp8(pwdata[dpl_pkg::OV_WLVL_LSB +: 8], dpl_pkg::WARN_LEVEL_MIN,
                                       dpl_pkg::WARN_LEVEL_MAX); // (R01)
        overload_warn_time   <= clamp6(pwdata[dpl_pkg::OV_WTIM_LSB +: 6], dpl_pkg::WARN_TIME_MAX); // (R03)
        overload_trip_level  <= clamp8(pwdata[dpl_pkg::OV_TLVL_LSB +: 8], dpl_pkg::TRIP_LEVEL_MIN,
                                       dpl_pkg::TRIP_LEVEL_MAX); // (R05)
        overload_trip_time   <= clamp6(pwdata[dpl_pkg::OV_TTIM_LSB +: 6], dpl_pkg::TRIP_TIME_MAX); // (R05)
        overload_trip_enable <= pwdata[dpl_pkg::OV_TEN_BIT]; // (R04)
      end
      if (hit_stall) begin
        stall_phase_mask    <= pwdata[2:0]; // (R10)
        stall_current_level <= clamp8(pwdata[15:8], dpl_pkg::STALL_LEVEL_MIN, dpl_pkg::STALL_LEVEL_MAX);
      end
      if (hit_phase) begin
        phase_loss_select   <= pwdata[1:0]; // (R12)
        motor_rated_current <= pwdata[31:16];
      end
      if (hit_osel) begin
        output_terminal_function <= (pwdata[4:0] > dpl_pkg::OUT_FUNC_MAX) ? 5'h00 : pwdata[4:0];
        relay_function           <= (pwdata[12:8] > dpl_pkg::OUT_FUNC_MAX) ? 5'h00 : pwdata[12:8];
      end
    end
  end

  generate
    for (gi = 0; gi < dpl_pkg::NUM_INPUTS; gi++) begin : g_infunc
      always_ff @(posedge mclk) begin
        if (reset) begin
          input_function[gi] <= 5'h00;
        end else if (apb_wr && hit_in) begin
          input_function[gi] <= (pwdata[gi*4 +: 4] == 4'h1) ? dpl_pkg::FUNC_EXT_NO :
                                (pwdata[gi*4 +: 4] == 4'h2) ? dpl_pkg::FUNC_EXT_NC : 5'h00; // (R17)
        end
      end
    end
  endgenerate

  // one-second timebase, restarts whenever neither level is exceeded
  always_ff @(posedge mclk) begin
    if (reset || !(over_warn || over_trip)) begin
      tick_cnt <= 16'h0000;
      ms_cnt   <= 10'h000;
    end else if (tick_cnt == 16'(dpl_pkg::TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
      ms_cnt   <= (ms_cnt == 10'(dpl_pkg::MS_PER_SEC - 1)) ? 10'h000 : ms_cnt + 10'h001;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // warning and trip duration counters saturate at their printed maxima
  always_ff @(posedge mclk) begin
    if (reset || !over_warn) begin
      warn_sec      <= 6'h00;
      overload_warn <= 1'b0;
    end else begin
      if (sec_tick && warn_sec < dpl_pkg::WARN_TIME_MAX) warn_sec <= warn_sec + 6'h01;
      overload_warn <= warn_sec >= overload_warn_time; // (R03)
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !over_trip) begin
      trip_sec <= 6'h00;
    end else if (sec_tick && trip_sec < dpl_pkg::TRIP_TIME_MAX) begin
      trip_sec <= trip_sec + 6'h01; // (R05)
    end
  end

  // latched faults; a new fault in the clear cycle still latches
  always_ff @(posedge mclk) begin
    if (reset) begin
      fault <= '0;
    end else begin
      fault.overload_trip <= ol_trip  | (fault.overload_trip & ~fault_clear); // (R21)
      fault.out_phase     <= out_loss | (fault.out_phase & ~fault_clear); // (R21)
      fault.in_phase      <= in_loss  | (fault.in_phase & ~fault_clear); // (R21)
      fault.capacitor     <= cap_trip | (fault.capacitor & ~fault_clear); // (R21)
      fault.ext_trip      <= (|ext_hit) | (fault.ext_trip & ~fault_clear); // (R18) (R19) (R21)
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      run_phase             <= dpl_pkg::DPL_RUN_STOP;
      stall_active          <= 1'b0;
      output_enable         <= 1'b0;
      stall_decelerate      <= 1'b0;
      stall_hold_decel      <= 1'b0;
      ramp_stretch          <= 1'b0;
      open_collector_output <= 1'b0;
      alarm_relay           <= 1'b0;
      fault_active          <= 1'b0;
    end else begin
      run_phase             <= next_run_phase;
      stall_active          <= stall_seen;
      output_enable         <= ~any_fault; // (R21)
      stall_decelerate      <= ~any_fault & (stall_accel | stall_const); // (R06) (R07)
      stall_hold_decel      <= ~any_fault & stall_decel; // (R08)
      ramp_stretch          <= ~any_fault & (stall_accel | stall_decel); // (R20)
      open_collector_output <= sel_out(output_terminal_function, overload_warn, stall_active, any_fault); // (R02)
      alarm_relay           <= sel_out(relay_function, overload_warn, stall_active, any_fault); // (R02)
      fault_active          <= any_fault;
    end
  end

  // apb read path and answer; zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  wire [31:0] rd_in;
  generate
    for (gi = 0; gi < dpl_pkg::NUM_INPUTS; gi++) begin : g_rdin
      assign rd_in[gi*4 +: 4] = (input_function[gi] == dpl_pkg::FUNC_EXT_NO) ? 4'h1 :
                                (input_function[gi] == dpl_pkg::FUNC_EXT_NC) ? 4'h2 : 4'h0;
    end
  endgenerate
  wire [31:0] rd_ovl = {overload_trip_enable, 1'b0, overload_trip_time, overload_trip_level,
                        2'b00, overload_warn_time, overload_warn_level};
  wire [31:0] rd_sta = {22'h000000, overload_warn, stall_active, over_trip, over_warn, 1'b0, fault};
  assign prdata = hit_ovl   ? rd_ovl :
                  hit_stall ? {16'h0000, stall_current_level, 5'h00, stall_phase_mask} :
                  hit_phase ? {motor_rated_current, 14'h0000, phase_loss_select} :
                  hit_osel  ? {19'h00000, relay_function, 3'h0, output_terminal_function} :
                  hit_in    ? rd_in :
                  hit_stat  ? rd_sta : 32'h00000000;
endmodule // dpl_top
`default_nettype wire

// >>> tb/dpl_checker.sv
// checker: port-level assertions for the drive protection logic
`timescale 1ns/1ns
`default_nettype none
module dpl_checker (
  // clock and apb
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // plant and contacts
  input wire logic [2:0]  output_phase_ok,
  input wire logic [2:0]  input_phase_ok,
  input wire logic        capacitor_worn,
  input wire logic        decelerating,
  input wire logic        running,
  input wire logic        dc_link_high,
  input wire logic [7:0]  input_contact,
  // outputs
  input wire logic        output_enable,
  input wire logic        stall_hold_decel,
  input wire logic        fault_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // shadow settings; pready is always high, so an access phase is a transfer
  logic [2:0]  mask;
  logic [1:0]  phs;
  logic [31:0] ins;
  logic        ext_hit;
  wire         wr  = psel && penable && pwrite;
  wire         clr = wr && paddr == dpl_pkg::ADDR_CONTROL && pwdata[0];
  always_ff @(posedge mclk) begin
    if (reset) begin
      mask <= 3'h0;
      phs  <= 2'h0;
      ins  <= 32'h0;
    end else if (wr) begin
      if (paddr == dpl_pkg::ADDR_STALL) mask <= pwdata[2:0];
      if (paddr == dpl_pkg::ADDR_PHASE) phs <= pwdata[1:0];
      if (paddr == dpl_pkg::ADDR_INPUTS) ins <= pwdata;
    end
  end
  always_comb begin
    ext_hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ext_hit |= (ins[4*i+:4] == 4'h1 && input_contact[i]) || (ins[4*i+:4] == 4'h2 && !input_contact[i]);
    end
  end
  AST_RESET_OUT: assert property (disable iff (1'b0) reset |=> !output_enable && !fault_active)
    else $error("outputs live after reset");
  AST_OE_CAUSE: assert property ($rose(output_enable) |-> !fault_active)
    else $error("output enabled with fault latched");
  AST_FAULT_OFF: assert property (fault_active |-> !output_enable)
    else $error("output on during fault");
  AST_KEEP: assert property (fault_active && !clr && !$past(clr) |=> fault_active)
    else $error("fault dropped without clear");
  AST_HOLD: assert property ((mask[2] && decelerating && dc_link_high && !fault_active) [*2] |-> stall_hold_decel)
    else $error("deceleration not paused");
  AST_NO_HOLD: assert property (!mask[2] [*2] |-> !stall_hold_decel)
    else $error("pause without mask bit");
  AST_OUT_PH: assert property (phs[0] && running && output_phase_ok != 3'h7 |-> ##[1:3] fault_active)
    else $error("output phase loss missed");
  AST_IN_PH: assert property (phs[1] && input_phase_ok != 3'h7 |-> ##[1:3] fault_active)
    else $error("input phase loss missed");
  AST_CAP: assert property (phs[1] && capacitor_worn |-> ##[1:3] fault_active)
    else $error("worn capacitor missed");
  AST_EXT: assert property (ext_hit |-> ##[1:3] fault_active)
    else $error("external trip missed");
  cvr_ext: cover property (ext_hit && fault_active);
  cvr_hold: cover property (stall_hold_decel);
  cvr_both: cover property (phs == 2'h3 && fault_active);
endmodule // dpl_checker
bind dpl_top dpl_checker u_checker (.*);
`default_nettype wire

// >>> tb/dpl_plant.sv
// power stage and contact model facing the protection logic
`timescale 1ns/1ns
`default_nettype none
module dpl_plant #(parameter logic [7:0] NC_WIRED = 8'h80) (
  // bench knobs
  input wire logic [15:0] load,
  input wire logic [1:0]  state,
  input wire logic [7:0]  ext_fault,
  // drive side
  input wire logic        output_enable,
  output logic     [15:0] motor_current,
  output logic            accelerating,
  output logic            decelerating,
  output logic            running,
  output logic     [7:0]  input_contact
);
  // no current flows while the stage is blocked, so an overload trip removes its own cause
  assign motor_current = output_enable ? load : 16'h0000;
  assign running       = state != 2'h0;
  assign accelerating  = state == 2'h1;
  assign decelerating  = state == 2'h3;
  assign input_contact = ext_fault ^ NC_WIRED;
endmodule // dpl_plant
`default_nettype wire

// >>> tb/dpl_top_tb.sv
// testbench: registers, stall, overload, phase loss and external trip
`timescale 1ns/1ns
`default_nettype none
module dpl_top_tb;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        mclk, reset, psel, penable, pwrite, pin_chk, f;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, dc_link_high, capacitor_worn;
  logic [2:0]  output_phase_ok, input_phase_ok;
  logic [15:0] motor_current, load;
  logic        accelerating, decelerating, running;
  logic [7:0]  input_contact, ext_fault;
  logic        output_enable, stall_decelerate, stall_hold_decel, ramp_stretch;
  logic        open_collector_output, alarm_relay, fault_active;
  logic [1:0]  state;
  logic [64:0] note;
  logic [64:0] notes[$];
  int          miscompares, n_tests, cycles;
  integer      seed;
  wire  [31:0] pins = {25'h0, output_enable, fault_active, stall_decelerate, stall_hold_decel,
                       ramp_stretch, open_collector_output, alarm_relay};
  dpl_top dut (.*);
  dpl_plant plant (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({a > dpl_pkg::ADDR_CONTROL, m, e & m});
    apb(1'b0, a, 32'h0);
  endtask
  // outputs are registered, so let them settle before sampling
  task automatic pk(input logic [31:0] e, input logic [31:0] m);
    notes.push_back({1'b0, m, e & m});
    repeat (3) @(posedge mclk);
    pin_chk <= 1'b1;
    @(posedge mclk);
    pin_chk <= 1'b0;
  endtask
  always @(posedge mclk) begin
    if ((psel && penable && pready && !pwrite) || pin_chk) begin
      note = notes.pop_front();
      n_tests++;
      if (((pin_chk ? pins : prdata) & note[63:32]) !== note[31:0] || (!pin_chk && pslverr !== note[64])) begin
        miscompares++;
        $display("ERROR at %0t: got %h expected %h", $time, pin_chk ? pins : prdata, note[31:0]);
      end
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'h9EDD;
    {psel, penable, pwrite, pin_chk, dc_link_high, capacitor_worn, reset} = 7'h01;
    {paddr, pwdata, load, state, ext_fault} = 70'h0;
    {output_phase_ok, input_phase_ok} = 6'h3F;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    pk(32'h40, 32'h7F);
    rd(dpl_pkg::ADDR_OVERLOAD, 32'hBCB40A96, ALL);
    rd(dpl_pkg::ADDR_STALL, 32'h00009600, ALL);
    rd(dpl_pkg::ADDR_PHASE, 32'h00640000, ALL);
    rd(dpl_pkg::ADDR_OUTSEL, 32'h0000110C, ALL);
    rd(12'h0FC, 32'h0, ALL);
    wr(dpl_pkg::ADDR_OVERLOAD, 32'hBCFF0AFF);
    rd(dpl_pkg::ADDR_OVERLOAD, 32'hBCC80A96, ALL);
    for (int i = 0; i < 20; i++) begin
      load <= 16'($random(seed)) & 16'h003F;
      state <= 2'($random(seed));
      ext_fault <= 8'($random(seed));
      pk(32'h40, 32'h60);
    end
    $display("test defaults finished");
    wr(dpl_pkg::ADDR_OVERLOAD, 32'hBCB40A96);
    ext_fault <= 8'h0;
    dc_link_high <= 1'b1;
    load <= 16'h0028;
    for (int m = 0; m < 8; m++) begin
      wr(dpl_pkg::ADDR_STALL, 32'h1E00 | m);
      for (int s = 1; s < 4; s++) begin
        state <= 2'(s);
        pk({25'h0, 2'b10, s == 1 && m[0] || s == 2 && m[1], s == 3 && m[2], 3'h0}, 32'h78);
      end
    end
    wr(dpl_pkg::ADDR_PHASE, 32'h00C80000);
    wr(dpl_pkg::ADDR_STALL, 32'h1E01);
    wr(dpl_pkg::ADDR_OUTSEL, 32'h1107);
    state <= 2'h1;
    pk(32'h40, 32'h70);
    load <= 16'h0050;
    pk(32'h56, 32'h7F);
    wr(dpl_pkg::ADDR_STALL, 32'h1E00);
    pk(32'h42, 32'h7B);
    wr(dpl_pkg::ADDR_PHASE, 32'h00640000);
    dc_link_high <= 1'b0;
    $display("test stall finished");
    wr(dpl_pkg::ADDR_OVERLOAD, 32'h00C8001E);
    wr(dpl_pkg::ADDR_OUTSEL, 32'h0505);
    state <= 2'h2;
    load <= 16'h0028;
    pk(32'h43, 32'h63);
    load <= 16'h0014;
    pk(32'h40, 32'h63);
    wr(dpl_pkg::ADDR_OVERLOAD, 32'h00C8011E);
    load <= 16'h0028;
    pk(32'h40, 32'h63);
    wr(dpl_pkg::ADDR_OVERLOAD, 32'h001E0096);
    load <= 16'h0064;
    pk(32'h40, 32'h60);
    wr(dpl_pkg::ADDR_OVERLOAD, 32'h801E0096);
    pk(32'h20, 32'h60);
    rd(dpl_pkg::ADDR_STATUS, 32'h10, 32'h1F);
    load <= 16'h0000;
    pk(32'h20, 32'h60);
    wr(dpl_pkg::ADDR_CONTROL, 32'h1);
    pk(32'h40, 32'h60);
    wr(dpl_pkg::ADDR_OVERLOAD, 32'hBCB40A96);
    $display("test overload finished");
    load <= 16'h0014;
    wr(dpl_pkg::ADDR_OUTSEL, 32'h1111);
    for (int sel = 0; sel < 4; sel++) begin
      wr(dpl_pkg::ADDR_PHASE, 32'h00640000 | sel);
      for (int k = 0; k < 3; k++) begin
        output_phase_ok <= k == 0 ? 3'h6 : 3'h7;
        input_phase_ok <= k == 1 ? 3'h3 : 3'h7;
        capacitor_worn <= k == 2;
        f = k == 0 ? sel[0] : sel[1];
        pk(f ? 32'h23 : 32'h40, 32'h63);
        rd(dpl_pkg::ADDR_STATUS, {28'h0, f, 3'h0} >> k, 32'h0E);
        {output_phase_ok, input_phase_ok, capacitor_worn} <= 7'h7E;
        wr(dpl_pkg::ADDR_CONTROL, 32'h1);
        pk(32'h40, 32'h60);
      end
    end
    $display("test phase loss finished");
    wr(dpl_pkg::ADDR_PHASE, 32'h00640000);
    wr(dpl_pkg::ADDR_INPUTS, 32'h21000000);
    rd(dpl_pkg::ADDR_INPUTS, 32'h21000000, ALL);
    pk(32'h40, 32'h60);
    for (int i = 6; i < 8; i++) begin
      ext_fault <= 8'h1 << i;
      pk(32'h20, 32'h60);
      rd(dpl_pkg::ADDR_STATUS, 32'h1, 32'h1F);
      ext_fault <= 8'h0;
      wr(dpl_pkg::ADDR_CONTROL, 32'h1);
      pk(32'h40, 32'h60);
    end
    $display("test external trip finished");
    give_verdict();
  end
endmodule // dpl_top_tb
`default_nettype wire
